// file: hw/bga_pkg.sv
package bga_pkg;

  // ****************************************************************
  // gap timing, in arbitration clock periods
  // ****************************************************************
  localparam logic [5:0] ACK_GAP_DETECT = 6'h04;
  localparam logic [5:0] ACK_GAP_DRIVE = 6'h08;
  localparam logic [5:0] SUB_GAP_DETECT = 6'h10;
  localparam logic [5:0] SUB_GAP_DRIVE = 6'h14;
  localparam logic [5:0] ARB_GAP_DETECT = 6'h1C;
  localparam logic [5:0] ARB_GAP_DRIVE = 6'h20;

  // ****************************************************************
  // arbitration sequence layout
  // ****************************************************************
  localparam int PRIO_BITS = 4;
  localparam int ARBNUM_BITS = 6;
  localparam int SEQ_BITS = PRIO_BITS + ARBNUM_BITS;
  localparam logic [3:0] SEQ_LAST_IDX = 4'h9;
  localparam logic [3:0] PRIO_FAIR = 4'h0;
  localparam logic [3:0] PRIO_CYCLE_START = 4'hF;
  localparam logic [3:0] PRIO_URGENT_MIN = 4'h1;
  localparam logic [3:0] PRIO_URGENT_MAX = 4'hE;
  localparam logic [2:0] ID_FULL_LEN = 3'h6;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0] ARB_NUMBER_RESET = 6'h00;
  localparam logic FAIR_ENABLE_RESET = 1'b1;

  // ****************************************************************
  // arbitration classes
  // ****************************************************************
  typedef enum logic [2:0] {
    CLS_FAIR = 3'h0,
    CLS_URGENT = 3'h1,
    CLS_CYCLE_START = 3'h2,
    CLS_ISOCH = 3'h3,
    CLS_IMMEDIATE = 3'h4
  } bga_class_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SEND = 3'b100
  } bga_state_t;

endpackage

// file: hw/bga_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser, one stage pair per bit
module bga_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// file: hw/bga_core.sv
`timescale 1ns/1ps
module bga_core
  import bga_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic arb_clk_i,
  input wire logic rx_data_line_i,
  input wire logic rx_strobe_line_i,
  input wire logic arb_req_i,
  input wire logic [2:0] arb_class_i,
  input wire logic [3:0] urgent_prio_i,
  input wire logic [5:0] node_identifier_i,
  input wire logic [2:0] node_id_len_i,
  input wire logic node_id_load_i,
  output logic tx_data_o,
  output logic tx_data_oe_o,
  output logic rx_bit_o,
  output logic rx_bit_valid_o,
  output logic bus_idle_o,
  output logic ack_gap_o,
  output logic sub_gap_o,
  output logic arb_reset_gap_o,
  output logic arb_busy_o,
  output logic arb_won_o,
  output logic arb_lost_o,
  output logic fair_enable_o
);

  // ****************************************************************
  // input synchronisation
  // ****************************************************************

  logic [2:0] pins_sync;
  logic data_s;
  logic strobe_s;
  logic arb_clk_s;

  bga_sync #(
    .WIDTH(3)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .async_i({arb_clk_i, rx_strobe_line_i, rx_data_line_i}),
    .sync_o(pins_sync)
  );

  // named taps of the synchronised pins
  assign data_s = pins_sync[0];
  assign strobe_s = pins_sync[1];
  assign arb_clk_s = pins_sync[2];

  // ****************************************************************
  // edge detection
  // ****************************************************************

  logic arb_clk_q;
  logic bit_clk_q;
  logic bit_clk;
  logic arb_tick;
  logic bit_edge;

  // previous samples, taken from synchronised copies only
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arb_clk_q <= 1'b0;
      bit_clk_q <= 1'b0;
    end else begin
      arb_clk_q <= arb_clk_s;
      bit_clk_q <= bit_clk;
    end
  end

  // recovered clock toggles once per bit cell on either line
  assign bit_clk = data_s ^ strobe_s;
  assign bit_edge = bit_clk ^ bit_clk_q;
  // gap counting and arbitration bits step on arbitration clock rising edges; received bits follow the recovered clock
  assign arb_tick = arb_clk_s & ~arb_clk_q;

  // ****************************************************************
  // receive bit extraction
  // ****************************************************************

  // data is stable around each recovered clock edge, so sample it there
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rx_bit_o <= 1'b0;
      rx_bit_valid_o <= 1'b0;
    end else begin
      rx_bit_valid_o <= bit_edge;
      if (bit_edge) begin
        rx_bit_o <= data_s;
      end
    end
  end

  // ****************************************************************
  // gap timing
  // ****************************************************************

  logic bus_idle;
  logic [5:0] idle_count;
  logic [5:0] next_idle_count;
  logic count_sat;
  logic ack_seen;
  logic sub_seen;
  logic arb_seen;
  logic arb_gap_start;

  // only both lines low counts as idle
  assign bus_idle = ~data_s & ~strobe_s;
  // counter saturates at the longest gap, nothing beyond it matters
  assign count_sat = (idle_count == ARB_GAP_DRIVE);
  assign next_idle_count = !bus_idle ? 6'h00 :
                           (arb_tick && !count_sat) ? idle_count + 6'h01 :
                           idle_count;

  assign ack_seen = (idle_count >= ACK_GAP_DETECT);
  assign sub_seen = (idle_count >= SUB_GAP_DETECT);
  assign arb_seen = (idle_count >= ARB_GAP_DETECT);
  // one-cycle mark when the reset gap is first reached
  assign arb_gap_start = arb_seen & ~arb_reset_gap_o;

  // idle period counter, restarted by any activity
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      idle_count <= 6'h00;
    end else begin
      idle_count <= next_idle_count;
    end
  end

  // registered gap flags
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      bus_idle_o <= 1'b0;
      ack_gap_o <= 1'b0;
      sub_gap_o <= 1'b0;
      arb_reset_gap_o <= 1'b0;
    end else begin
      bus_idle_o <= bus_idle;
      ack_gap_o <= ack_seen;
      sub_gap_o <= sub_seen;
      arb_reset_gap_o <= arb_seen;
    end
  end

  // ****************************************************************
  // arbitration number
  // ****************************************************************

  logic [5:0] arb_number;
  logic [5:0] next_arb_number;
  logic id_loaded;
  logic [2:0] id_shift;

  // short identifiers arrive right aligned and move to the top
  assign id_shift = (node_id_len_i >= ID_FULL_LEN) ? 3'h0 : ID_FULL_LEN - node_id_len_i;
  assign next_arb_number = node_identifier_i << id_shift;

  // captured once after reset, then on each software load
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arb_number <= ARB_NUMBER_RESET;
      id_loaded <= 1'b0;
    end else begin
      id_loaded <= 1'b1;
      if (node_id_load_i || !id_loaded) begin
        arb_number <= next_arb_number;
      end
    end
  end

  // ****************************************************************
  // priority and waited-for gap per class
  // ****************************************************************

  logic [3:0] urgent_prio;
  logic [3:0] req_prio;
  logic [5:0] drive_count;
  logic class_immediate;
  logic class_fair;
  logic class_allowed;
  logic gap_ready;

  // urgent never borrows the two reserved levels
  assign urgent_prio = (urgent_prio_i < PRIO_URGENT_MIN) ? PRIO_URGENT_MIN :
                       (urgent_prio_i > PRIO_URGENT_MAX) ? PRIO_URGENT_MAX :
                       urgent_prio_i;

  assign req_prio = (arb_class_i == CLS_URGENT) ? urgent_prio :
                    (arb_class_i == CLS_CYCLE_START) ? PRIO_CYCLE_START :
                    (arb_class_i == CLS_ISOCH) ? PRIO_FAIR :
                    PRIO_FAIR;

  // isochronous and acknowledge wait the short gap, the rest the subaction gap
  assign drive_count = (arb_class_i == CLS_ISOCH || arb_class_i == CLS_IMMEDIATE) ?
                       ACK_GAP_DRIVE : SUB_GAP_DRIVE;

  assign class_immediate = (arb_class_i == CLS_IMMEDIATE);
  assign class_fair = (arb_class_i == CLS_FAIR);
  // a fair node whose enable is spent waits for the reset gap to refill it
  assign class_allowed = !class_fair || fair_enable_o;
  assign gap_ready = arb_tick && bus_idle && (idle_count >= drive_count - 6'h01)
                     && class_allowed;

  // ****************************************************************
  // arbitration sequencer
  // ****************************************************************

  bga_state_t state;
  bga_state_t next_state;
  logic [9:0] seq_shift;
  logic [3:0] bit_idx;
  logic sent_bit;
  logic bit_lost;
  logic last_bit;
  logic win_now;
  logic lose_now;
  logic start_send;
  logic grant_immediate;

  assign sent_bit = seq_shift[9];
  // a zero we sent cannot read back high unless someone outranks us
  assign bit_lost = !sent_bit && data_s;
  assign last_bit = (bit_idx == SEQ_LAST_IDX);
  assign start_send = (state == ST_WAIT) && gap_ready && !class_immediate;
  assign grant_immediate = (state == ST_WAIT) && gap_ready && class_immediate;
  assign lose_now = (state == ST_SEND) && arb_tick && bit_lost;
  assign win_now = (state == ST_SEND) && arb_tick && !bit_lost && last_bit;

  // next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (arb_req_i) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!arb_req_i || grant_immediate) begin
          next_state = ST_IDLE;
        end else if (start_send) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (lose_now || win_now) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // sequence register: priority then number, one bit per arbitration tick
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      seq_shift <= 10'h000;
      bit_idx <= 4'h0;
    end else if (start_send) begin
      seq_shift <= {req_prio, arb_number};
      bit_idx <= 4'h0;
    end else if (state == ST_SEND && arb_tick) begin
      seq_shift <= {seq_shift[8:0], 1'b0};
      bit_idx <= bit_idx + 4'h1;
    end
  end

  // ****************************************************************
  // bus drive
  // ****************************************************************

  logic drive_next;

  // only a one is driven; a zero releases, so the bus ORs all nodes
  assign drive_next = (next_state == ST_SEND) &&
                      (start_send ? req_prio[3] : (arb_tick ? seq_shift[8] : sent_bit));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tx_data_o <= 1'b0;
      tx_data_oe_o <= 1'b0;
    end else begin
      tx_data_o <= drive_next;
      tx_data_oe_o <= drive_next;
    end
  end

  // ****************************************************************
  // results and fairness
  // ****************************************************************

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      arb_won_o <= 1'b0;
      arb_lost_o <= 1'b0;
      arb_busy_o <= 1'b0;
    end else begin
      arb_won_o <= win_now || grant_immediate;
      arb_lost_o <= lose_now;
      arb_busy_o <= (next_state != ST_IDLE);
    end
  end

  // reset gap refills the enable and beats a same-cycle fair win
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fair_enable_o <= FAIR_ENABLE_RESET;
    end else if (arb_gap_start) begin
      fair_enable_o <= 1'b1;
    end else if (win_now && class_fair) begin
      fair_enable_o <= 1'b0;
    end
  end

endmodule

// file: verif/bga_peer.sv
`timescale 1ns/1ps
// ****************************************
// far node: data-strobe frame, then contest
// ****************************************
module bga_peer (
  input wire logic arb_clk_i,
  input wire logic bus_data_i,
  input wire logic bus_strobe_i,
  input wire logic frame_i,
  input wire logic [7:0] frame_bits_i,
  input wire logic arm_i,
  input wire logic [9:0] seq_i,
  input wire logic [5:0] drive_i,
  output logic data_o,
  output logic strobe_o,
  output logic busy_o
);
  int idle = 0;
  int fb = 0;
  int pos = -1;
  initial begin
    data_o = 1'b0;
    strobe_o = 1'b0;
    busy_o = 1'b0;
  end
  // lines move 6 ns after the tick, so the core never sees a bit change with its own tick
  always @(posedge arb_clk_i) begin
    idle = (bus_data_i || bus_strobe_i) ? 0 : idle + 1;
    if (busy_o) begin
      if (fb == 0) begin
        {busy_o, data_o, strobe_o} <= #6 3'h0; // released lines read unasserted
      end else begin
        fb = fb - 1;
        data_o <= #6 frame_bits_i[fb];
        strobe_o <= #6 strobe_o ^ (data_o == frame_bits_i[fb]);
      end
    end else if (frame_i) begin
      busy_o <= #6 1'b1;
      fb = 8;
    end else if (pos >= 0) begin
      if (pos == 0 || (!seq_i[pos] && bus_data_i)) begin
        pos = -1;
        data_o <= #6 1'b0;
      end else begin
        pos = pos - 1;
        data_o <= #6 seq_i[pos];
      end
    end else if (arm_i && idle == int'(drive_i)) begin
      pos = 9;
      data_o <= #6 seq_i[9];
    end
  end
endmodule

// file: verif/bga_core_chk.sv
`timescale 1ns/1ps
// ****************************************
// port checks for the gap and arbitration core
// ****************************************
module bga_core_chk
  import bga_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [2:0] arb_class_i,
  input wire logic tx_data_o,
  input wire logic tx_data_oe_o,
  input wire logic bus_idle_o,
  input wire logic ack_gap_o,
  input wire logic sub_gap_o,
  input wire logic arb_reset_gap_o,
  input wire logic arb_busy_o,
  input wire logic arb_won_o,
  input wire logic arb_lost_o,
  input wire logic fair_enable_o
);
  logic [9:0] idle_run;
  logic sent;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // idle length in core clocks, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    if (srst_i || !bus_idle_o) begin
      idle_run <= 10'h000;
    end else if (idle_run != 10'h3FF) begin
      idle_run <= idle_run + 10'h001;
    end
  end
  // first drive of a request is the one tied to the gap
  always_ff @(posedge clk_i) begin
    if (srst_i || !arb_busy_o) begin
      sent <= 1'b0;
    end else if (tx_data_oe_o) begin
      sent <= 1'b1;
    end
  end
  sequence s_quiet;
    !tx_data_oe_o [*8];
  endsequence
  sequence s_first_drive;
    $rose(tx_data_oe_o) && !sent;
  endsequence
  chk_drive_ones: assert property (tx_data_oe_o |-> tx_data_o) else $error("enable with zero bit");
  chk_ack_gap_time: assert property ($rose(ack_gap_o) |-> idle_run >= 10'h01E && idle_run <= 10'h038)
    else $error("ack gap timing");
  chk_sub_gap_time: assert property ($rose(sub_gap_o) |-> idle_run >= 10'h0AE && idle_run <= 10'h0C8)
    else $error("subaction gap timing");
  chk_rst_gap_time: assert property ($rose(arb_reset_gap_o) |-> idle_run >= 10'h13E && idle_run <= 10'h158)
    else $error("reset gap timing");
  chk_lost_release: assert property (arb_lost_o |=> s_quiet) else $error("drive after loss");
  chk_won_release: assert property (arb_won_o |=> s_quiet) else $error("drive after win");
  chk_bit_stands: assert property ($rose(tx_data_oe_o) |-> tx_data_oe_o [*8]) else $error("short bit");
  chk_drive_gap: assert property (s_first_drive |-> ack_gap_o && (arb_class_i == CLS_ISOCH || sub_gap_o))
    else $error("drive before gap");
  chk_fair_refill: assert property ($rose(fair_enable_o) |-> arb_reset_gap_o) else $error("refill no gap");
  chk_fair_clear: assert property ($fell(fair_enable_o) |-> arb_won_o || $past(arb_won_o))
    else $error("enable drop no win");
endmodule
bind bga_core bga_core_chk u_chk (.clk_i, .srst_i, .arb_class_i, .tx_data_o, .tx_data_oe_o, .bus_idle_o, .ack_gap_o,
  .sub_gap_o, .arb_reset_gap_o, .arb_busy_o, .arb_won_o, .arb_lost_o, .fair_enable_o);

// file: verif/tb_backplane_gap_and_arbitration.sv
`timescale 1ns/1ps
module tb_backplane_gap_and_arbitration;
  import bga_pkg::*;
  logic clk_i = 1'b0;
  logic arb_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic arb_req_i = 1'b0;
  logic [2:0] arb_class_i = 3'h0;
  logic [3:0] urgent_prio_i = 4'h0;
  logic [5:0] node_identifier_i = 6'h2D;
  logic [2:0] node_id_len_i = 3'h6;
  logic node_id_load_i = 1'b0;
  logic tx_data_o, tx_data_oe_o, rx_bit_o, rx_bit_valid_o, bus_idle_o, ack_gap_o, sub_gap_o, arb_reset_gap_o;
  logic arb_busy_o, arb_won_o, arb_lost_o, fair_enable_o, p_data, p_strobe, p_busy;
  logic frame = 1'b0;
  logic p_arm = 1'b0;
  logic [9:0] p_seq = 10'h000;
  logic [5:0] p_drive = 6'h00;
  logic [7:0] rx_sh = 8'h00;
  int rx_n = 0, won_n = 0, lost_n = 0, n_mismatch = 0, cmp_count = 0;
  // wired-or bus: our own drive is read back like anyone else's
  wire logic bus_data = p_data | (tx_data_oe_o & tx_data_o);
  // ****************************************
  // clocks, design and far node
  // ****************************************
  always #2 clk_i = ~clk_i;
  always #24 arb_clk_i = ~arb_clk_i;
  bga_core dut (.clk_i, .srst_i, .arb_clk_i, .rx_data_line_i(bus_data), .rx_strobe_line_i(p_strobe), .arb_req_i,
    .arb_class_i, .urgent_prio_i, .node_identifier_i, .node_id_len_i, .node_id_load_i, .tx_data_o, .tx_data_oe_o,
    .rx_bit_o, .rx_bit_valid_o, .bus_idle_o, .ack_gap_o, .sub_gap_o, .arb_reset_gap_o, .arb_busy_o, .arb_won_o,
    .arb_lost_o, .fair_enable_o);
  bga_peer peer (.arb_clk_i, .bus_data_i(bus_data), .bus_strobe_i(p_strobe), .frame_i(frame), .frame_bits_i(8'hA5),
    .arm_i(p_arm), .seq_i(p_seq), .drive_i(p_drive), .data_o(p_data), .strobe_o(p_strobe), .busy_o(p_busy));
  // result pulses and received bits are tallied as they pass
  always @(posedge clk_i) begin
    if (arb_won_o === 1'b1) won_n++;
    if (arb_lost_o === 1'b1) lost_n++;
    if (rx_bit_valid_o === 1'b1) begin
      rx_n++;
      rx_sh = {rx_sh[6:0], rx_bit_o};
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // request goes up only once the core has seen the frame on the lines, or a saturated gap grants at once
  task automatic send_frame(input logic req);
    int n;
    n = 0;
    frame = 1'b1;
    while ((p_busy !== 1'b1 || bus_idle_o !== 1'b0) && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    arb_req_i = req;
    while (p_busy === 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    frame = 1'b0;
    if (n >= 300) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  task automatic contest(input logic [2:0] cls, input logic [3:0] up, input logic [9:0] pseq, input int start);
    logic [9:0] dseq, obs;
    logic [3:0] pr;
    logic lost, plost, b;
    pr = (cls == CLS_CYCLE_START) ? PRIO_CYCLE_START : (cls != CLS_URGENT) ? PRIO_FAIR :
      (up == 4'h0) ? PRIO_URGENT_MIN : (up == 4'hF) ? PRIO_URGENT_MAX : up;
    dseq = (cls == CLS_IMMEDIATE) ? 10'h000 : {pr, 6'(node_identifier_i << (3'h6 - node_id_len_i))};
    lost = 1'b0;
    plost = (pseq == 10'h000);
    // predicted wired-or contest, bit by bit from the top
    for (int i = 9; i >= 0; i--) begin
      obs[i] = dseq[i] & ~lost;
      b = obs[i] | (pseq[i] & ~plost);
      lost = lost | (b & ~obs[i]);
      plost = plost | (b & ~pseq[i]);
    end
    @(negedge clk_i);
    arb_class_i = cls;
    urgent_prio_i = up;
    p_seq = pseq;
    p_arm = |pseq;
    p_drive = start[5:0];
    won_n = 0;
    lost_n = 0;
    send_frame(1'b1);
    for (int k = 1; k <= start + 10; k++) begin
      @(posedge arb_clk_i);
      #40;
      check(16'(tx_data_oe_o & tx_data_o), (k >= start && k < start + 10) ? 16'(obs[start + 9 - k]) : 16'h0000);
      // a held request rearms after the result, so drop it before the next tick
      if (won_n + lost_n != 0) begin
        arb_req_i = 1'b0;
      end
    end
    arb_req_i = 1'b0;
    p_arm = 1'b0;
    check(16'(won_n), 16'(!lost));
    check(16'(lost_n), 16'(lost));
    $display("contest class %0d done", cls);
  endtask
  task automatic t_rx_gap;
    @(negedge clk_i);
    rx_n = 0;
    send_frame(1'b0);
    for (int k = 1; k <= 30; k++) begin
      @(posedge arb_clk_i);
      #40;
      check(16'({ack_gap_o, sub_gap_o, arb_reset_gap_o, fair_enable_o}), 16'({k >= 4, k >= 16, k >= 28, k >= 28}));
    end
    check(16'(rx_n), 16'h0008);
    check(16'(rx_sh), 16'h00A5);
    $display("receive and gap test done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_i);
    @(negedge clk_i);
    srst_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check(16'({tx_data_oe_o, arb_busy_o, arb_won_o, arb_lost_o, fair_enable_o}), 16'h0001);
    contest(CLS_FAIR, 4'h0, 10'h000, 20);
    check(16'(fair_enable_o), 16'h0000);
    t_rx_gap();
    contest(CLS_ISOCH, 4'h0, 10'h02B, 8);
    contest(CLS_CYCLE_START, 4'h0, 10'h000, 20);
    contest(CLS_URGENT, 4'h0, 10'h17F, 20);
    contest(CLS_URGENT, 4'hF, 10'h0FF, 20);
    @(negedge clk_i);
    node_identifier_i = 6'h05;
    node_id_len_i = 3'h3;
    node_id_load_i = 1'b1;
    @(negedge clk_i);
    node_id_load_i = 1'b0;
    contest(CLS_ISOCH, 4'h0, 10'h000, 8);
    contest(CLS_IMMEDIATE, 4'h0, 10'h000, 8);
    give_verdict();
  end
endmodule
